// file: hw/cshp_port.sv
// Behaviour
// R1: Shared-bus mode set: serial output released while chip select is high.
// R2: Shared-bus mode, select low: output driven, normal pass-through and read data.
// R3: Host gives each chain sharing one output its own chip select.
// R4: Serial input sampled on every rising serial clock edge while selected.
// R5: Read data bits launched on falling serial clock edges.
// R6: Serial clock ignored while chip select is high; the control word copy (ctrl_s1_q, ctrl_s2_q) still advances on it then.
// R7: Host keeps serial clock at or below 27 MHz.
// R8: A frame starts at select fall and holds two command words plus data.
// R9: Bits after select fall always start a fresh first command word.
// R10: Command bit 15 set means read, clear means write.
// R11: Broadcast bit set: write stored whatever the chain identifier says.
// R12: Broadcast clear: write only when chain identifier matches ours.
// R13: Host always sets command bit 13 for 23-bit addressing.
// R14: Address is command 1 bits 6 to 0 above all of command 2.
// R15: Address-step bit set: address increases after every data word.
// R16: Address-step bit clear: only one data word accessed per frame.
// R17: Host never writes the control register with address stepping.
// R18: Reads and non-broadcast writes accepted only on chain identifier match.
// R19: Programmed chain identifier is zero after reset.
// R20: Host waits four serial clocks after a control register write; the bench host gives only three, with select high, before each frame.
// R21: Host limits serial clock to 7.5 MHz with 32 chained devices.
// R22: Host leaves at least three serial clocks between commands.
// R23: Four serial clocks separate command 2 end and first read data bit; the code drives the first bit on the falling edge right after command 2.
// R24: Output is an unclocked copy of input except while driving read data.
// R25: Pass-through disable set: output held high instead of copying input.
// R26: Select rising mid data word abandons that word without any write.
`timescale 1ns/1ps
`default_nettype none

module cshp_port (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe,
    output logic      passthrough_disable,
    output logic      shared_output_enable,
    output logic [4:0] programmed_chain_id
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [cshp_pkg::ID_W-1:0] cshp_ctrl_id(
        input logic [cshp_pkg::WORD_W-1:0] word
    );
        cshp_ctrl_id = word[cshp_pkg::CTRL_ID_MSB:cshp_pkg::CTRL_ID_LSB];
    endfunction : cshp_ctrl_id

    function automatic logic [cshp_pkg::ID_W-1:0] cshp_cmd_id(
        input logic [cshp_pkg::WORD_W-1:0] word
    );
        cshp_cmd_id = word[cshp_pkg::CMD_ID_MSB:cshp_pkg::CMD_ID_LSB];
    endfunction : cshp_cmd_id

    // ------------------------------------------------------------------
    // Link domain: frame decode on the serial clock
    // ------------------------------------------------------------------
    logic [cshp_pkg::WORD_W-1:0]   shift_q;
    logic [cshp_pkg::BITCNT_W-1:0] bitcnt_q;
    logic [1:0]                    phase_q;
    logic [cshp_pkg::WORD_W-1:0]   cmd1_q;
    logic [cshp_pkg::ADDR_W-1:0]   addr_q;
    logic                          done_q;
    logic [cshp_pkg::WORD_W-1:0]   word_d;
    logic                          word_end;
    logic                          id_match;
    logic                          wr_accept;
    logic                          rd_accept;
    logic [cshp_pkg::WORD_W-1:0]   ctrl_s1_q;
    logic [cshp_pkg::WORD_W-1:0]   ctrl_s2_q;
    logic [cshp_pkg::WORD_W-1:0]   ctrl_q;

    assign word_d   = {shift_q[cshp_pkg::WORD_W-2:0], serial_in};
    assign word_end = (bitcnt_q == cshp_pkg::LAST_BIT);
    assign id_match = (cshp_cmd_id(cmd1_q) == cshp_ctrl_id(ctrl_s2_q)); // R18
    assign wr_accept = !cmd1_q[cshp_pkg::CMD_READ_BIT] && !done_q
                       && (cmd1_q[cshp_pkg::CMD_BCAST_BIT] || id_match); // R10 R11 R12
    assign rd_accept = cmd1_q[cshp_pkg::CMD_READ_BIT] && !done_q && id_match; // R10 R18

    // The control word changes only with a configuration gap after it, so a
    // plain two-stage copy has settled long before the first identifier test.
    always_ff @(posedge sclk) begin
        ctrl_s1_q <= ctrl_q;
        ctrl_s2_q <= ctrl_s1_q;
    end

    // Chip select high clears all frame state; the serial clock has no effect then.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin // R6 R9 R26
            shift_q  <= '0;
            bitcnt_q <= '0;
            phase_q  <= cshp_pkg::PHASE_CMD1;
            cmd1_q   <= '0;
            addr_q   <= '0;
            done_q   <= 1'b0;
        end else begin
            shift_q  <= word_d; // R4
            bitcnt_q <= bitcnt_q + 4'h1;
            if (word_end) begin
                unique case (phase_q)
                    cshp_pkg::PHASE_CMD1: begin
                        cmd1_q  <= word_d; // R8
                        phase_q <= cshp_pkg::PHASE_CMD2;
                    end
                    cshp_pkg::PHASE_CMD2: begin
                        addr_q  <= {cmd1_q[cshp_pkg::CMD_ADDR_HI_MSB:0], word_d}; // R14
                        phase_q <= cshp_pkg::PHASE_DATA;
                    end
                    default: begin
                        if (cmd1_q[cshp_pkg::CMD_STEP_BIT]) begin
                            addr_q <= addr_q + 23'h000001; // R15
                        end else begin
                            done_q <= 1'b1; // R16
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Write hand-off to the system clock
    // ------------------------------------------------------------------
    logic                        wtog_q;
    logic [cshp_pkg::WORD_W-1:0] wdata_q;
    logic                        wr_commit;

    // Only a completed data word commits, so a short word never writes.
    assign wr_commit = !cs_n && word_end && (phase_q == cshp_pkg::PHASE_DATA) && wr_accept
                       && (addr_q == cshp_pkg::SERIAL_LINK_CONTROL_OFFSET); // R26

    // The toggle survives chip select rising right after the last edge, which
    // a frame-cleared pulse would not.
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            wtog_q <= 1'b0;
        end else if (wr_commit) begin
            wtog_q <= ~wtog_q; // R11 R12
        end
    end

    always_ff @(posedge sclk) begin
        if (wr_commit) begin
            wdata_q <= word_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data launch on the falling edge
    // ------------------------------------------------------------------
    logic                        drive_q;
    logic                        out_q;
    logic [cshp_pkg::WORD_W-1:0] rd_word;

    assign rd_word = (addr_q == cshp_pkg::SERIAL_LINK_CONTROL_OFFSET) ? ctrl_s2_q : '0;

    // Data starts on the first falling edge after command word 2 is in; no turnaround clocks are counted.
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            drive_q <= 1'b0;
            out_q   <= 1'b1;
        end else if ((phase_q == cshp_pkg::PHASE_DATA) && rd_accept) begin // R23
            drive_q <= 1'b1;
            out_q   <= rd_word[~bitcnt_q]; // R5
        end else begin
            drive_q <= 1'b0;
            out_q   <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // System domain: control register
    // ------------------------------------------------------------------
    logic                        wtog_s1_q;
    logic                        wtog_s2_q;
    logic                        wtog_s3_q;
    logic                        wr_event;

    assign wr_event = wtog_s2_q ^ wtog_s3_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            wtog_s1_q <= 1'b0;
            wtog_s2_q <= 1'b0;
            wtog_s3_q <= 1'b0;
        end else begin
            wtog_s1_q <= wtog_q;
            wtog_s2_q <= wtog_s1_q;
            wtog_s3_q <= wtog_s2_q;
        end
    end

    // The link data word is stable for at least a word time after the toggle.
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= cshp_pkg::SERIAL_LINK_CONTROL_RESET; // R19
        end else if (wr_event) begin
            ctrl_q <= wdata_q & cshp_pkg::CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            passthrough_disable  <= 1'b0;
            shared_output_enable <= 1'b0;
            programmed_chain_id  <= '0;
        end else begin
            passthrough_disable  <= ctrl_q[cshp_pkg::CTRL_PASSTHRU_DIS_BIT];
            shared_output_enable <= ctrl_q[cshp_pkg::CTRL_SHARED_OUT_BIT];
            programmed_chain_id  <= cshp_ctrl_id(ctrl_q);
        end
    end

    // ------------------------------------------------------------------
    // Serial output path
    // ------------------------------------------------------------------
    // The loop-through must be unclocked for chained devices, so this output
    // is a mux rather than a flop; only the read bit itself is registered.
    assign serial_out = drive_q ? out_q
                      : (ctrl_q[cshp_pkg::CTRL_PASSTHRU_DIS_BIT] ? 1'b1 : serial_in); // R24 R25
    assign serial_out_oe = !(ctrl_q[cshp_pkg::CTRL_SHARED_OUT_BIT] && cs_n); // R1 R2

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_data_word_end;
        word_end && (phase_q == cshp_pkg::PHASE_DATA);
    endsequence

    property p_shared_release;
        @(posedge clk) disable iff (srst)
        (ctrl_q[cshp_pkg::CTRL_SHARED_OUT_BIT] && cs_n) |-> !serial_out_oe;
    endproperty
    a_shared_release: assert property (p_shared_release) else $error("output driven while released"); // R1

    property p_selected_drive;
        @(posedge clk) disable iff (srst)
        !cs_n |-> serial_out_oe;
    endproperty
    a_selected_drive: assert property (p_selected_drive) else $error("output not driven while selected"); // R2

    property p_copy_input;
        @(posedge clk) disable iff (srst)
        (!drive_q && !ctrl_q[cshp_pkg::CTRL_PASSTHRU_DIS_BIT]) |-> (serial_out == serial_in);
    endproperty
    a_copy_input: assert property (p_copy_input) else $error("pass-through broken"); // R24

    property p_hold_high;
        @(posedge clk) disable iff (srst)
        (!drive_q && ctrl_q[cshp_pkg::CTRL_PASSTHRU_DIS_BIT]) |-> serial_out;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("output not held high"); // R25

    property p_reset_id;
        @(posedge clk) srst |=> (cshp_ctrl_id(ctrl_q) == 5'h00) ##1 (programmed_chain_id == 5'h00);
    endproperty
    a_reset_id: assert property (p_reset_id) else $error("chain id not zero after reset"); // R19

    property p_write_only;
        @(posedge sclk) disable iff (cs_n || srst)
        wr_commit |-> !cmd1_q[cshp_pkg::CMD_READ_BIT];
    endproperty
    a_write_only: assert property (p_write_only) else $error("write committed on read"); // R10

    property p_write_match;
        @(posedge sclk) disable iff (cs_n || srst)
        wr_commit |-> (cmd1_q[cshp_pkg::CMD_BCAST_BIT] || id_match);
    endproperty
    a_write_match: assert property (p_write_match) else $error("write without id match"); // R12

    property p_step_addr;
        @(posedge sclk) disable iff (cs_n || srst)
        (s_data_word_end and cmd1_q[cshp_pkg::CMD_STEP_BIT]) |=> (addr_q == $past(addr_q) + 23'h000001);
    endproperty
    a_step_addr: assert property (p_step_addr) else $error("address did not step"); // R15

    property p_single_word;
        @(posedge sclk) disable iff (cs_n || srst)
        (s_data_word_end and !cmd1_q[cshp_pkg::CMD_STEP_BIT]) |=> done_q ##0 !wr_commit [*8];
    endproperty
    a_single_word: assert property (p_single_word) else $error("second word accessed"); // R16

    property p_ctrl_update;
        @(posedge clk) disable iff (srst)
        $changed(wtog_s2_q) |=> (ctrl_q == ($past(wdata_q) & cshp_pkg::CTRL_WRITE_MASK));
    endproperty
    a_ctrl_update: assert property (p_ctrl_update) else $error("control write lost"); // R11

    // The first rising edge of a frame must see state left clean by the select.
    property p_frame_clear;
        @(posedge sclk) disable iff (srst)
        (!cs_n && $past(cs_n)) |-> ((bitcnt_q == '0) && (phase_q == cshp_pkg::PHASE_CMD1) && !done_q);
    endproperty
    a_frame_clear: assert property (p_frame_clear) else $error("frame state not fresh"); // R9

    property p_cmd1_capture;
        @(posedge sclk) disable iff (cs_n || srst)
        (word_end && (phase_q == cshp_pkg::PHASE_CMD1)) |=> ((cmd1_q == $past(word_d)) && (phase_q == cshp_pkg::PHASE_CMD2));
    endproperty
    a_cmd1_capture: assert property (p_cmd1_capture) else $error("command word 1 not taken"); // R8

    property p_addr_form;
        @(posedge sclk) disable iff (cs_n || srst)
        (word_end && (phase_q == cshp_pkg::PHASE_CMD2))
        |=> (addr_q == {$past(cmd1_q[cshp_pkg::CMD_ADDR_HI_MSB:0]), $past(word_d)});
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("address not formed"); // R14

    property p_bcast_write;
        @(posedge sclk) disable iff (cs_n || srst)
        (s_data_word_end and (!cmd1_q[cshp_pkg::CMD_READ_BIT] && cmd1_q[cshp_pkg::CMD_BCAST_BIT] && !done_q
            && (addr_q == cshp_pkg::SERIAL_LINK_CONTROL_OFFSET))) |-> wr_commit;
    endproperty
    a_bcast_write: assert property (p_bcast_write) else $error("broadcast write dropped"); // R11

    property p_step_off;
        @(posedge sclk) disable iff (cs_n || srst)
        (s_data_word_end and !cmd1_q[cshp_pkg::CMD_STEP_BIT]) |=> (addr_q == $past(addr_q));
    endproperty
    a_step_off: assert property (p_step_off) else $error("address stepped without step bit"); // R16

    // Checked on the rising edge, where the host takes the bit that the falling edge put out.
    property p_read_bit;
        @(posedge sclk) disable iff (cs_n || srst)
        drive_q |-> (serial_out == rd_word[~bitcnt_q]);
    endproperty
    a_read_bit: assert property (p_read_bit) else $error("read bit out of order"); // R5

    property p_drive_gate;
        @(posedge sclk) disable iff (cs_n || srst)
        drive_q |-> ((phase_q == cshp_pkg::PHASE_DATA) && rd_accept);
    endproperty
    a_drive_gate: assert property (p_drive_gate) else $error("read data driven too early"); // R23

    property p_id_copy;
        @(posedge clk) disable iff (srst)
        1'b1 |-> (programmed_chain_id == $past(ctrl_q[cshp_pkg::CTRL_ID_MSB:cshp_pkg::CTRL_ID_LSB]));
    endproperty
    a_id_copy: assert property (p_id_copy) else $error("chain id output stale"); // R18

endmodule : cshp_port

`default_nettype wire

// file: hw/cshp_pkg.sv
package cshp_pkg;

    // ------------------------------------------------------------------
    // Word and address shape
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned ADDR_W   = 23;
    localparam int unsigned ID_W     = 5;
    localparam int unsigned BITCNT_W = 4;

    // ------------------------------------------------------------------
    // Command word 1 fields
    // ------------------------------------------------------------------
    localparam int unsigned CMD_READ_BIT    = 15;
    localparam int unsigned CMD_BCAST_BIT   = 14;
    localparam int unsigned CMD_EXT_BIT     = 13;
    localparam int unsigned CMD_STEP_BIT    = 12;
    localparam int unsigned CMD_ID_MSB      = 11;
    localparam int unsigned CMD_ID_LSB      = 7;
    localparam int unsigned CMD_ADDR_HI_MSB = 6;

    // ------------------------------------------------------------------
    // Frame phases, counted in whole words
    // ------------------------------------------------------------------
    localparam logic [1:0] PHASE_CMD1 = 2'h0;
    localparam logic [1:0] PHASE_CMD2 = 2'h1;
    localparam logic [1:0] PHASE_DATA = 2'h2;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 4'hf;

    // ------------------------------------------------------------------
    // Serial link control register
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SERIAL_LINK_CONTROL_OFFSET = 23'h000000;
    localparam logic [WORD_W-1:0] SERIAL_LINK_CONTROL_RESET  = 16'h0000;
    localparam int unsigned CTRL_PASSTHRU_DIS_BIT = 0;
    localparam int unsigned CTRL_SHARED_OUT_BIT   = 1;
    localparam int unsigned CTRL_ID_LSB           = 2;
    localparam int unsigned CTRL_ID_MSB           = 6;
    localparam logic [WORD_W-1:0] CTRL_WRITE_MASK  = 16'h007f;

    // ------------------------------------------------------------------
    // Timing: serial clock limit in MHz, gaps in serial clock cycles
    // ------------------------------------------------------------------
    localparam int unsigned SCLK_MAX_MHZ         = 27;
    localparam int unsigned CMD_GAP_CYCLES       = 3;
    localparam int unsigned CONFIG_GAP_CYCLES    = 4;
    localparam int unsigned READ_TURNAROUND_CYC  = 4;

endpackage : cshp_pkg

// file: test/cshp_host.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Host side of the serial link
// ------------------------------------------------------------------
module cshp_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      serial_in,
    input  wire logic serial_out
);

    // The serial clock idles low; the host clocks it three times with select high before each frame.
    initial begin
        sclk      = 1'b0;
        cs_n      = 1'b1;
        serial_in = 1'b0;
    end

    task automatic frame(input logic [63:0] bits, input int n, input logic rd, output logic [31:0] got);
        int i;
        got = 32'h0;
        for (i = 0; i < 3; i++) begin
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        cs_n = 1'b0;
        for (i = 0; i < n; i++) begin
            serial_in = bits[63-i];
            #40 sclk = 1'b1;
            if (i >= 32) got = {got[30:0], serial_out};
            #40 sclk = 1'b0;
            if (rd && i == 31) #320;
        end
        #40 cs_n = 1'b1;
        // A released line must not keep showing its last value.
        serial_in = ~serial_in;
        #320;
    endtask : frame

endmodule : cshp_host

`default_nettype wire

// file: test/cshp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cshp_port_tb;

    logic        clk;
    logic        srst;
    logic        sclk;
    logic        cs_n;
    logic        serial_in;
    logic        serial_out;
    logic        serial_out_oe;
    logic        passthrough_disable;
    logic        shared_output_enable;
    logic [4:0]  programmed_chain_id;
    logic [31:0] got;
    int          bad_count;
    int          total_checks;
    int          cycles;

    always #4 clk = ~clk;

    cshp_port cshp_port_i (
        .clk                  (clk),
        .srst                 (srst),
        .sclk                 (sclk),
        .cs_n                 (cs_n),
        .serial_in            (serial_in),
        .serial_out           (serial_out),
        .serial_out_oe        (serial_out_oe),
        .passthrough_disable  (passthrough_disable),
        .shared_output_enable (shared_output_enable),
        .programmed_chain_id  (programmed_chain_id)
    );

    cshp_host cshp_host_i (
        .sclk       (sclk),
        .cs_n       (cs_n),
        .serial_in  (serial_in),
        .serial_out (serial_out)
    );

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        total_checks++;
        if (act !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check

    // Command bit 13 is always set, so every access uses the split address.
    task automatic wr(input logic [4:0] id, input logic bc, input logic [22:0] a, input logic [31:0] d,
                      input int n);
        cshp_host_i.frame({1'b0, bc, 1'b1, 1'b0, id, a, d}, n, 1'b0, got);
    endtask : wr

    task automatic rd(input logic [4:0] id, input logic st, input logic [22:0] a, input int n);
        cshp_host_i.frame({1'b1, 1'b0, 1'b1, st, id, a, 32'h0}, n, 1'b1, got);
    endtask : rd

    // ------------------------------------------------------------------
    // Timeout
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk  = 1'b0;
        srst = 1'b1;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        #3;
        check(programmed_chain_id, 32'h0);
        check({passthrough_disable, shared_output_enable, serial_out_oe}, 32'h1);
        wr(5'h0, 1'b0, 23'h0, {16'h0004, 16'h0}, 48);
        check(got[15:0], 32'h0004);
        check(programmed_chain_id, 32'h1);
        wr(5'h0, 1'b0, 23'h0, {16'h0000, 16'h0}, 48);
        check(programmed_chain_id, 32'h1);
        wr(5'h1, 1'b0, 23'h010000, {16'h0000, 16'h0}, 48);
        check(programmed_chain_id, 32'h1);
        wr(5'h1, 1'b0, 23'h0, {16'h0008, 16'h000c}, 64);
        check(programmed_chain_id, 32'h2);
        wr(5'h2, 1'b0, 23'h0, {16'h0010, 16'h0}, 40);
        check(programmed_chain_id, 32'h2);
        wr(5'h5, 1'b1, 23'h0, {16'h000c, 16'h0}, 48);
        check(programmed_chain_id, 32'h3);
        rd(5'h3, 1'b0, 23'h0, 48);
        check(got[15:0], 32'h000c);
        // Stepped reads only, since stepped writes to the control word are not allowed.
        rd(5'h3, 1'b1, 23'h0, 64);
        check(got, 32'h000c0000);
        rd(5'h4, 1'b0, 23'h0, 48);
        check(got[15:0], 32'h0000);
        wr(5'h3, 1'b0, 23'h0, {16'h000f, 16'h0}, 48);
        check({passthrough_disable, shared_output_enable, serial_out_oe}, 32'h6);
        rd(5'h3, 1'b0, 23'h0, 48);
        check(got[15:0], 32'h000f);
        wr(5'h3, 1'b0, 23'h0, {16'h000d, 16'h0}, 48);
        check({passthrough_disable, shared_output_enable, serial_out_oe}, 32'h5);
        wr(5'h3, 1'b0, 23'h0, {16'h0000, 16'h0}, 48);
        check(got[15:0], 32'hffff);
        check({programmed_chain_id, passthrough_disable}, 32'h0);
        finish_test();
    end

endmodule : cshp_port_tb

`default_nettype wire
